// file: rtl/ccfc_core.v
// control-flow and compare execution slice with an AHB-Lite register port
//
// Summary of operation
// - indirect call loads pc from pointer, 3 cycles
// - absolute call loads constant address, 4 cycles
// - subroutine return pops pc, 4 cycles
// - interrupt return pops pc, sets I, 4 cycles
// - equal registers skip next instruction, no flags
// - carry compare updates Z N V C H
// - immediate compare updates Z N V C H
// - register bit clear/set skips next instruction
// - io bit clear/set skips next instruction
// - flag set branches pc plus k plus one
// - flag clear branches pc plus k plus one
// - carry clear branches pc plus k plus one
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ccfc_defs.vh"
module ccfc_core
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire [7:0]  io_pin_data,
  output reg  [15:0] stack_wdata,
  output reg         stack_push,
  output reg         stack_pop,
  output reg  [15:0] pc_out,
  output reg  [7:0]  status_flags,
  output wire        busy
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  reg        state_r;
  reg [15:0] pc_r;
  reg [15:0] pc_nxt;
  reg [7:0]  flags_nxt;
  reg [8:0]  ctrl_r;
  reg [7:0]  opa_r;
  reg [7:0]  opb_r;
  reg [7:0]  imm_r;
  reg [15:0] ptr_r;
  reg [15:0] stack_r;
  reg [15:0] target_r;
  reg [2:0]  cnt_r;
  reg [2:0]  last_cycles_r;
  reg        last_taken_r;
  reg [7:0]  io_s1_r;
  reg [7:0]  io_s2_r;
  reg        wr_pend_r;
  reg [7:0]  wr_addr_r;
  reg        rd_go;

  wire [3:0] op        = ctrl_r[`CCFC_CTRL_OP_LO +: 4];
  wire [2:0] bit_sel   = ctrl_r[`CCFC_CTRL_BIT_LO +: 3];
  wire       next_long = ctrl_r[`CCFC_CTRL_LONG];
  wire [7:0] flags_new;
  wire       taken;
  wire [2:0] cycles;
  wire       addr_ok   = hsel & htrans[1] & hready & clk_en;
  wire [15:0] ret_addr = pc_r + (op == `CCFC_OP_CALL ? 16'h0002 : 16'h0001);
  wire [15:0] offset   = {{8{imm_r[7]}}, imm_r};

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign busy      = (state_r == ST_EXEC);

  ccfc_decide u_decide
  (
    .op        (op),
    .bit_sel   (bit_sel),
    .next_long (next_long),
    .opa       (opa_r),
    .opb       (opb_r),
    .imm       (imm_r),
    .io_data   (io_s2_r),
    .flags     (status_flags),
    .flags_new (flags_new),
    .taken     (taken),
    .cycles    (cycles)
  );

  // io pins are sampled twice before the decision logic sees them
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
    end
    else if (clk_en)
    begin
      io_s1_r <= io_pin_data;
      io_s2_r <= io_s1_r;
    end
  end

  always @*
  begin
    rd_go  = 1'b0;
    pc_nxt = pc_r;
    case (op)
      `CCFC_OP_INDIRECT_CALL : pc_nxt = ptr_r;
      `CCFC_OP_CALL  : pc_nxt = target_r;
      `CCFC_OP_RET,
      `CCFC_OP_INTERRUPT_EXIT  : pc_nxt = stack_r;
      `CCFC_OP_BRS,
      `CCFC_OP_BRC,
      `CCFC_OP_BRANCH_CARRY_CLEAR  : pc_nxt = taken ? pc_r + offset + 16'h0001 : pc_r + 16'h0001;
      `CCFC_OP_COMPARE_SKIP_EQUAL,
      `CCFC_OP_SKRC,
      `CCFC_OP_SKRS,
      `CCFC_OP_SKIC,
      `CCFC_OP_SKIS  : pc_nxt = pc_r + (taken ? (next_long ? 16'h0003 : 16'h0002) : 16'h0001);
      default        : pc_nxt = pc_r + 16'h0001;
    endcase
    flags_nxt = flags_new;
    if (addr_ok && !hwrite)
      rd_go = 1'b1;
  end

  // register writes land in the data phase; execution starts on a go write
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r     <= 1'b0;
      wr_addr_r     <= 8'h00;
      ctrl_r        <= 9'h000;
      opa_r         <= 8'h00;
      opb_r         <= 8'h00;
      imm_r         <= 8'h00;
      ptr_r         <= 16'h0000;
      stack_r       <= 16'h0000;
      target_r      <= 16'h0000;
      pc_r          <= `CCFC_RST_PC;
      status_flags  <= `CCFC_RST_FLAGS;
      pc_out        <= `CCFC_RST_PC;
      state_r       <= ST_IDLE;
      cnt_r         <= 3'h0;
      last_cycles_r <= 3'h0;
      last_taken_r  <= 1'b0;
      stack_push    <= 1'b0;
      stack_pop     <= 1'b0;
      stack_wdata   <= 16'h0000;
      hrdata        <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      wr_pend_r  <= addr_ok & hwrite;
      wr_addr_r  <= haddr[7:0];
      stack_push <= 1'b0;
      stack_pop  <= 1'b0;
      if (wr_pend_r)
      begin
        case (wr_addr_r)
          `CCFC_OFS_CTRL :
          begin
            // writes while busy are dropped so the running instruction stays consistent
            if (state_r == ST_IDLE)
            begin
              ctrl_r <= hwdata[8:0];
              if (hwdata[`CCFC_CTRL_GO])
              begin
                state_r <= ST_EXEC;
                cnt_r   <= 3'h0;
              end
            end
          end
          `CCFC_OFS_PC    : if (state_r == ST_IDLE) pc_r <= hwdata[15:0];
          `CCFC_OFS_FLAGS : if (state_r == ST_IDLE) status_flags <= hwdata[7:0];
          `CCFC_OFS_OPA   : opa_r <= hwdata[7:0];
          `CCFC_OFS_OPB   : opb_r <= hwdata[7:0];
          `CCFC_OFS_IMM   :
          begin
            imm_r    <= hwdata[7:0];
            target_r <= hwdata[31:16];
          end
          `CCFC_OFS_PTR   : ptr_r <= hwdata[15:0];
          `CCFC_OFS_STACK : stack_r <= hwdata[15:0];
          default         : ;
        endcase
      end
      else if (state_r == ST_EXEC)
      begin
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h0)
        begin
          if (op == `CCFC_OP_INDIRECT_CALL || op == `CCFC_OP_CALL)
          begin
            stack_wdata <= ret_addr;
            stack_push  <= 1'b1;
          end
          if (op == `CCFC_OP_RET || op == `CCFC_OP_INTERRUPT_EXIT)
            stack_pop <= 1'b1;
        end
        if (cnt_r == cycles - 3'h1)
        begin
          // state commits on the last cycle, after the push has gone out
          pc_r          <= pc_nxt;
          pc_out        <= pc_nxt;
          status_flags  <= flags_nxt;
          last_cycles_r <= cycles;
          last_taken_r  <= taken;
          state_r       <= ST_IDLE;
        end
      end
      if (rd_go)
      begin
        case (haddr[7:0])
          `CCFC_OFS_CTRL   : hrdata <= {23'h000000, ctrl_r};
          `CCFC_OFS_STATUS : hrdata <= {27'h0000000, last_taken_r, last_cycles_r, state_r};
          `CCFC_OFS_PC     : hrdata <= {16'h0000, pc_r};
          `CCFC_OFS_FLAGS  : hrdata <= {24'h000000, status_flags};
          `CCFC_OFS_OPA    : hrdata <= {24'h000000, opa_r};
          `CCFC_OFS_OPB    : hrdata <= {24'h000000, opb_r};
          `CCFC_OFS_IMM    : hrdata <= {target_r, 8'h00, imm_r};
          `CCFC_OFS_PTR    : hrdata <= {16'h0000, ptr_r};
          `CCFC_OFS_STACK  : hrdata <= {16'h0000, stack_r};
          `CCFC_OFS_CYCLES : hrdata <= {29'h0000000, cycles};
          default          : hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/ccfc_decide.v
// combinational decision: flag results, skip/branch condition, cycle count
`timescale 1ns/1ps
`default_nettype none
`include "ccfc_defs.vh"
module ccfc_decide
(
  input  wire [3:0]  op,
  input  wire [2:0]  bit_sel,
  input  wire        next_long,
  input  wire [7:0]  opa,
  input  wire [7:0]  opb,
  input  wire [7:0]  imm,
  input  wire [7:0]  io_data,
  input  wire [7:0]  flags,
  output reg  [7:0]  flags_new,
  output reg         taken,
  output reg  [2:0]  cycles
);
  reg  [7:0] sub;
  reg  [7:0] rr;
  reg        cin;
  reg        is_cmp;
  reg        n_r;
  reg        v_r;
  reg        z_r;
  always @*
  begin
    rr        = (op == `CCFC_OP_CPI) ? imm : opb;
    cin       = (op == `CCFC_OP_CPC) ? flags[`CCFC_FLG_C] : 1'b0;
    is_cmp    = (op == `CCFC_OP_CPC) || (op == `CCFC_OP_CPI);
    sub       = opa - rr - {7'h00, cin};
    n_r       = sub[7];
    v_r       = (opa[7] & ~rr[7] & ~sub[7]) | (~opa[7] & rr[7] & sub[7]);
    // carry-in compare keeps zero only if it was already set, so multi-byte compares chain
    z_r       = (sub == 8'h00) & ((op == `CCFC_OP_CPC) ? flags[`CCFC_FLG_Z] : 1'b1);
    flags_new = flags;
    if (is_cmp)
    begin
      flags_new[`CCFC_FLG_Z] = z_r;
      flags_new[`CCFC_FLG_N] = n_r;
      flags_new[`CCFC_FLG_V] = v_r;
      flags_new[`CCFC_FLG_S] = n_r ^ v_r;
      flags_new[`CCFC_FLG_C] = (~opa[7] & rr[7]) | (rr[7] & sub[7]) | (sub[7] & ~opa[7]);
      flags_new[`CCFC_FLG_H] = (~opa[3] & rr[3]) | (rr[3] & sub[3]) | (sub[3] & ~opa[3]);
    end
    if (op == `CCFC_OP_INTERRUPT_EXIT)
      flags_new[`CCFC_FLG_I] = 1'b1;
    case (op)
      `CCFC_OP_COMPARE_SKIP_EQUAL : taken = (opa == opb);
      `CCFC_OP_SKRC : taken = ~opa[bit_sel];
      `CCFC_OP_SKRS : taken = opa[bit_sel];
      `CCFC_OP_SKIC : taken = ~io_data[bit_sel];
      `CCFC_OP_SKIS : taken = io_data[bit_sel];
      `CCFC_OP_BRS  : taken = flags[bit_sel];
      `CCFC_OP_BRC  : taken = ~flags[bit_sel];
      `CCFC_OP_BRANCH_CARRY_CLEAR : taken = ~flags[`CCFC_FLG_C];
      default       : taken = 1'b0;
    endcase
    case (op)
      `CCFC_OP_INDIRECT_CALL : cycles = `CCFC_CYC_INDIRECT_CALL;
      `CCFC_OP_CALL  : cycles = `CCFC_CYC_CALL;
      `CCFC_OP_RET,
      `CCFC_OP_INTERRUPT_EXIT  : cycles = `CCFC_CYC_RET;
      `CCFC_OP_COMPARE_SKIP_EQUAL,
      `CCFC_OP_SKRC,
      `CCFC_OP_SKRS,
      `CCFC_OP_SKIC,
      `CCFC_OP_SKIS  : cycles = taken ? (next_long ? 3'h3 : 3'h2) : `CCFC_CYC_ONE;
      `CCFC_OP_BRS,
      `CCFC_OP_BRC,
      `CCFC_OP_BRANCH_CARRY_CLEAR  : cycles = taken ? 3'h2 : `CCFC_CYC_ONE;
      default        : cycles = `CCFC_CYC_ONE;
    endcase
  end
endmodule
`default_nettype wire

// file: rtl/ccfc_defs.vh
// constants for the control-flow and compare slice
`ifndef CCFC_DEFS_VH
`define CCFC_DEFS_VH
// register offsets (byte addresses)
`define CCFC_OFS_CTRL    8'h00
`define CCFC_OFS_STATUS  8'h04
`define CCFC_OFS_PC      8'h08
`define CCFC_OFS_FLAGS   8'h0C
`define CCFC_OFS_OPA     8'h10
`define CCFC_OFS_OPB     8'h14
`define CCFC_OFS_IMM     8'h18
`define CCFC_OFS_PTR     8'h1C
`define CCFC_OFS_STACK   8'h20
`define CCFC_OFS_CYCLES  8'h24
// ctrl fields: [0] go, [4:1] operation, [7:5] bit select, [8] next insn is two words
`define CCFC_CTRL_GO     0
`define CCFC_CTRL_OP_LO  1
`define CCFC_CTRL_BIT_LO 5
`define CCFC_CTRL_LONG   8
// status_flags bit positions
`define CCFC_FLG_C 0
`define CCFC_FLG_Z 1
`define CCFC_FLG_N 2
`define CCFC_FLG_V 3
`define CCFC_FLG_S 4
`define CCFC_FLG_H 5
`define CCFC_FLG_T 6
`define CCFC_FLG_I 7
// operation codes
`define CCFC_OP_INDIRECT_CALL   4'h0
`define CCFC_OP_CALL    4'h1
`define CCFC_OP_RET     4'h2
`define CCFC_OP_INTERRUPT_EXIT    4'h3
`define CCFC_OP_COMPARE_SKIP_EQUAL    4'h4
`define CCFC_OP_CPC     4'h5
`define CCFC_OP_CPI     4'h6
`define CCFC_OP_SKRC    4'h7
`define CCFC_OP_SKRS    4'h8
`define CCFC_OP_SKIC    4'h9
`define CCFC_OP_SKIS    4'hA
`define CCFC_OP_BRS     4'hB
`define CCFC_OP_BRC     4'hC
`define CCFC_OP_BRANCH_CARRY_CLEAR    4'hD
// cycle counts
`define CCFC_CYC_INDIRECT_CALL  3'h3
`define CCFC_CYC_CALL   3'h4
`define CCFC_CYC_RET    3'h4
`define CCFC_CYC_ONE    3'h1
`define CCFC_RST_PC     16'h0000
`define CCFC_RST_FLAGS  8'h00
`endif

// file: verif/ccfc_core_chk.sv
// port assertions for the control-flow and compare slice
`timescale 1ns/1ps
`default_nettype none
module ccfc_core_chk
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        stack_push,
  input wire logic        stack_pop,
  input wire logic [15:0] pc_out,
  input wire logic [7:0]  status_flags,
  input wire logic        busy
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_go;
    $rose(busy);
  endsequence
  sequence s_run;
    busy ##1 busy;
  endsequence
  property p_okay;
    hreadyout && !hresp;
  endproperty
  property p_span;
    s_go |-> ##[1:4] !busy;
  endproperty
  property p_pc_hold;
    s_run |-> $stable(pc_out);
  endproperty
  property p_flag_hold;
    s_run |-> $stable(status_flags);
  endproperty
  property p_push_busy;
    stack_push |-> busy;
  endproperty
  property p_push_once;
    stack_push |=> !stack_push;
  endproperty
  property p_push_end;
    stack_push |-> ##[1:4] $fell(busy);
  endproperty
  property p_pop_busy;
    stack_pop |-> busy ##1 !stack_pop;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not zero-wait okay");
  a_span: assert property (p_span)
    else $error("instruction ran too long");
  a_pc_hold: assert property (p_pc_hold)
    else $error("pc moved mid instruction");
  a_flag_hold: assert property (p_flag_hold)
    else $error("flags moved mid instruction");
  a_push_busy: assert property (p_push_busy)
    else $error("push while idle");
  a_push_once: assert property (p_push_once)
    else $error("push longer than one cycle");
  a_push_end: assert property (p_push_end)
    else $error("call did not end after push");
  a_pop_busy: assert property (p_pop_busy)
    else $error("bad pop pulse");
endmodule
`default_nettype wire

// file: verif/cpu_control_flow_compare_bench.sv
// self-checking bench for the control-flow and compare slice
`timescale 1ns/1ps
`default_nettype none
`include "ccfc_defs.vh"
module cpu_control_flow_compare_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  io_pin_data = 8'h0;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire  [15:0] stack_wdata;
  wire         stack_push;
  wire         stack_pop;
  wire  [15:0] pc_out;
  wire  [7:0]  status_flags;
  wire         busy;
  logic        rd_dp = 1'b0;
  logic [15:0] exp_push = 16'h0;
  logic [31:0] mon_m;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  int          failures = 0;
  int          n_tests = 0;
  int          n_push = 0;
  int          n_pop = 0;
  ccfc_core dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .io_pin_data(io_pin_data),
    .stack_wdata(stack_wdata), .stack_push(stack_push), .stack_pop(stack_pop),
    .pc_out(pc_out), .status_flags(status_flags), .busy(busy));
  always #4 hclk = ~hclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // a read notes its expectation in the address phase; the monitor pops it
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic [31:0] m);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    if (!wr) q_exp.push_back(d);
    if (!wr) q_msk.push_back(m);
    do @(posedge hclk); while (!hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (!hreadyout);
  endtask
  function automatic logic [7:0] subf(input logic [7:0] a, b, f, input logic c, ch);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'b0, a} - {1'b0, b} - {8'h0, c};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
    subf = f;
    subf[0] = r[8];
    // zero is chained for the carry compare so multi-byte compares work
    subf[1] = (r[7:0] == 8'h0) && (f[1] || !ch);
    subf[2] = r[7];
    subf[3] = (a[7] & !b[7] & !r[7]) | (!a[7] & b[7] & r[7]);
    subf[4] = subf[2] ^ subf[3];
    subf[5] = h[4];
  endfunction
  task automatic run_op(input logic [3:0] op, input logic eq);
    logic [15:0] pc, ep, ptr, stk;
    logic [31:0] imm;
    logic [7:0]  f, ef, a, b, io;
    logic [2:0]  bs, ec;
    logic        lg, t;
    int          n;
    pc  = 16'($urandom);
    f   = 8'($urandom);
    a   = 8'($urandom);
    b   = eq ? a : 8'($urandom);
    imm = $urandom;
    ptr = 16'($urandom);
    stk = 16'($urandom);
    io  = 8'($urandom);
    bs  = 3'($urandom);
    lg  = 1'($urandom);
    io_pin_data <= io;
    ef = f;
    t  = 1'b0;
    case (op)
      4'h4: t = a == b;
      4'h5: ef = subf(a, b, f, f[0], 1'b1);
      4'h6: ef = subf(a, imm[7:0], f, 1'b0, 1'b0);
      4'h7: t = !a[bs];
      4'h8: t = a[bs];
      4'h9: t = !io[bs];
      4'hA: t = io[bs];
      4'hB: t = f[bs];
      4'hC: t = !f[bs];
      4'hD: t = !f[0];
      default: ;
    endcase
    ec = op > 4'h3 ? 3'h1 : op == 4'h0 ? 3'h3 : 3'h4;
    ep = op == 4'h0 ? ptr : op == 4'h1 ? imm[31:16] : op < 4'h4 ? stk : pc + 16'h1;
    if (op == 4'h3) ef[7] = 1'b1;
    if (t) ec = op < 4'hB ? 3'h2 + {2'h0, lg} : 3'h2;
    if (t) ep = op < 4'hB ? pc + 16'h2 + {15'h0, lg} : pc + {{8{imm[7]}}, imm[7:0]} + 16'h1;
    exp_push = pc + (op == 4'h1 ? 16'h2 : 16'h1);
    xfer(`CCFC_OFS_PC, 1'b1, {16'h0, pc}, 32'h0);
    xfer(`CCFC_OFS_FLAGS, 1'b1, {24'h0, f}, 32'h0);
    xfer(`CCFC_OFS_OPA, 1'b1, {24'h0, a}, 32'h0);
    xfer(`CCFC_OFS_OPB, 1'b1, {24'h0, b}, 32'h0);
    xfer(`CCFC_OFS_IMM, 1'b1, imm, 32'h0);
    xfer(`CCFC_OFS_PTR, 1'b1, {16'h0, ptr}, 32'h0);
    xfer(`CCFC_OFS_STACK, 1'b1, {16'h0, stk}, 32'h0);
    n_push = 0;
    n_pop  = 0;
    xfer(`CCFC_OFS_CTRL, 1'b1, {23'h0, lg, bs, op, 1'b1}, 32'h0);
    n = 0;
    // poll on the falling edge so a flag updated at the rising edge has settled
    do
    begin
      @(negedge hclk);
      n++;
    end
    while (busy !== 1'b0 && n < 20);
    if (n == 20) failures++;
    if (n == 20) finish_test();
    chk({16'h0, pc_out}, {16'h0, ep}, "pc_out");
    chk({24'h0, status_flags}, {24'h0, ef}, "flags");
    chk(32'(n_push), (op < 4'h2) ? 32'h1 : 32'h0, "pushes");
    chk(32'(n_pop), (op == 4'h2 || op == 4'h3) ? 32'h1 : 32'h0, "pops");
    xfer(`CCFC_OFS_PC, 1'b0, {16'h0, ep}, 32'h0000FFFF);
    xfer(`CCFC_OFS_STATUS, 1'b0, {27'h0, t, ec, 1'b0}, 32'h0000001F);
    xfer(`CCFC_OFS_CYCLES, 1'b0, {29'h0, ec}, 32'h00000007);
  endtask
  always @(posedge hclk)
  begin
    if (rd_dp)
    begin
      mon_m = q_msk.pop_front();
      chk(hrdata & mon_m, q_exp.pop_front() & mon_m, "read");
    end
    if (stack_push)
      chk({16'h0, stack_wdata}, {16'h0, exp_push}, "push");
    if (stack_push)
      n_push++;
    if (stack_pop)
      n_pop++;
    rd_dp <= hsel & htrans[1] & !hwrite & hreadyout;
  end
  initial
  begin
    #200_000;
    failures++;
    finish_test();
  end
  initial
  begin
    void'($urandom(47));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 42; i++)
      run_op(4'(i % 14), i < 14);
    xfer(8'h40, 1'b0, 32'h0, 32'hFFFFFFFF);
    repeat (3) @(posedge hclk);
    finish_test();
  end
endmodule
bind ccfc_core ccfc_core_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .stack_push(stack_push), .stack_pop(stack_pop), .pc_out(pc_out),
  .status_flags(status_flags), .busy(busy));
`default_nettype wire
